// ===== flash_outcome_pkg.sv
// Purpose: Constants for the flash program/erase outcome register block.
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, one word per register.
// Notes: Outcome register byte holds four enable/flag pairs.
package flash_outcome_pkg;

    // =========================================================
    // Register offsets (byte addresses)
    localparam logic [3:0] OFS_OUTCOME = 4'h0;
    localparam logic [3:0] OFS_EVT_STATUS = 4'h4;
    localparam logic [3:0] OFS_EVT_MASK = 4'h8;
    localparam logic [3:0] OFS_STATE = 4'hc;

    // =========================================================
    // Outcome register layout: slot i owns bits 2i+1 (enable) and 2i (flag)
    localparam int SLOTS = 4;
    localparam int PAIR_W = 2;
    localparam int EN_OFS = 1;
    localparam int FLAG_OFS = 0;
    localparam int SLOT_PROG_DONE = 3;
    localparam int SLOT_PROG_FAIL = 2;
    localparam int SLOT_ERASE_DONE = 1;
    localparam int SLOT_ERASE_FAIL = 0;
    localparam logic [7:0] OUTCOME_RESET = 8'h00;

    // =========================================================
    // Event status / mask layout
    localparam int EVT_W = 5;
    localparam int EVT_LOCK = 4;
    localparam logic [4:0] EVT_RESET = 5'h00;

    // =========================================================
    // Block state register layout
    localparam int ST_BLOCKED = 0;
    localparam int ST_PROG_RUN = 1;
    localparam int ST_ERASE_RUN = 2;
    localparam int ST_STUCK = 3;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_PROG,
        OP_ERASE
    } op_state_t;

endpackage

// ===== flash_outcome_flag.sv
// Purpose: One sticky outcome flag with hardware set/clear and write-zero clear.
// Assumes: All strobes are one-cycle pulses on clock.
// Notes: A hardware set wins over any clear in the same cycle.
`timescale 1ns/1ns
module flash_outcome_flag (
    input wire logic clock,
    input wire logic rst,
    input wire logic set_pulse,
    input wire logic hw_clear,
    input wire logic sw_clear,
    output logic q
);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q <= 1'b0;
        end else if (set_pulse) begin
            q <= 1'b1;
        end else if (hw_clear || sw_clear) begin
            q <= 1'b0;
        end
    end

endmodule

// ===== flash_outcome_regs.sv
// Purpose: Flash program/erase outcome flags, enables, interrupt and lock.
// Assumes: Algorithm strobes are synchronous one-cycle pulses.
// Notes: Avalon-MM slave with one wait state per access.
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
module flash_outcome_regs
    import flash_outcome_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic rmw_access,
    input wire logic op_start,
    input wire logic op_is_erase,
    input wire logic op_end,
    input wire logic flash_stuck_indication,
    input wire logic reset_cmd,
    output logic prog_erase_blocked,
    output logic irq
);

    // =========================================================
    // Parameter check
    generate
        if (ADDR_W < 4) begin : g_bad_addr
            $error("ADDR_W must be at least 4");
        end
    endgenerate

    // =========================================================
    // Declarations
    logic ack_reg;
    logic [7:0] rd_byte;
    logic [31:0] rd_value;
    logic wr_ok;
    logic wr_outcome;
    logic wr_evt_status;
    logic wr_evt_mask;
    logic [3:0] addr_lo;
    logic hi_zero;
    op_state_t state_reg;
    op_state_t state_next;
    logic accept;
    logic start_prog;
    logic start_erase;
    logic end_prog;
    logic end_erase;
    logic [SLOTS-1:0] irq_en_reg;
    logic [SLOTS-1:0] flag_q;
    logic [SLOTS-1:0] flag_set;
    logic [SLOTS-1:0] flag_hw_clear;
    logic [SLOTS-1:0] flag_sw_clear;
    logic [SLOTS-1:0] flag_running;
    logic lock_set;
    logic [EVT_W-1:0] evt_reg;
    logic [EVT_W-1:0] evt_mask_reg;
    logic [EVT_W-1:0] evt_set;

    // =========================================================
    // Avalon handshake: one wait state, write acts at the released edge
    assign addr_lo = address[3:0];
    assign hi_zero = (address >> 4) == '0;
    assign waitrequest = (read || write) && !ack_reg;
    assign wr_ok = write && ack_reg && byteenable[0] && hi_zero;
    assign wr_outcome = wr_ok && (addr_lo == OFS_OUTCOME);
    assign wr_evt_status = wr_ok && (addr_lo == OFS_EVT_STATUS);
    assign wr_evt_mask = wr_ok && (addr_lo == OFS_EVT_MASK);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read || write) && !ack_reg;
        end
    end

    // =========================================================
    // Operation tracking
    assign accept = (state_reg == OP_IDLE) && !prog_erase_blocked;
    assign start_prog = op_start && accept && !op_is_erase;
    assign start_erase = op_start && accept && op_is_erase;
    assign end_prog = op_end && (state_reg == OP_PROG);
    assign end_erase = op_end && (state_reg == OP_ERASE);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            OP_IDLE: begin
                // Starts are refused while blocked
                if (start_prog) begin
                    state_next = OP_PROG;
                end else if (start_erase) begin
                    state_next = OP_ERASE;
                end
            end
            OP_PROG: begin
                if (op_end) begin
                    state_next = OP_IDLE;
                end
            end
            OP_ERASE: begin
                if (op_end) begin
                    state_next = OP_IDLE;
                end
            end
            default: begin
                state_next = OP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= OP_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // =========================================================
    // Outcome flags
    always_comb begin
        flag_set = '0;
        flag_hw_clear = '0;
        flag_set[SLOT_PROG_DONE] = end_prog && !flash_stuck_indication;
        flag_set[SLOT_PROG_FAIL] = end_prog && flash_stuck_indication;
        flag_set[SLOT_ERASE_DONE] = end_erase && !flash_stuck_indication;
        flag_set[SLOT_ERASE_FAIL] = end_erase && flash_stuck_indication;
        flag_hw_clear[SLOT_PROG_DONE] = flash_stuck_indication || start_prog;
        flag_hw_clear[SLOT_PROG_FAIL] = start_prog;
        flag_hw_clear[SLOT_ERASE_DONE] = flash_stuck_indication || start_erase;
        flag_hw_clear[SLOT_ERASE_FAIL] = start_erase;
    end

    always_comb begin
        flag_running = '0;
        flag_running[SLOT_PROG_DONE] = state_reg == OP_PROG;
        flag_running[SLOT_PROG_FAIL] = state_reg == OP_PROG;
        flag_running[SLOT_ERASE_DONE] = state_reg == OP_ERASE;
        flag_running[SLOT_ERASE_FAIL] = state_reg == OP_ERASE;
    end

    genvar gi;
    generate
        for (gi = 0; gi < SLOTS; gi++) begin : g_flag
            assign flag_sw_clear[gi] = wr_outcome && !writedata[gi*PAIR_W+FLAG_OFS];
            flash_outcome_flag u_flag (
                .clock(clock),
                .rst(rst),
                .set_pulse(flag_set[gi]),
                .hw_clear(flag_hw_clear[gi]),
                .sw_clear(flag_sw_clear[gi]),
                .q(flag_q[gi])
            );
        end
    endgenerate

    // =========================================================
    // Interrupt enables
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_en_reg <= '0;
        end else if (wr_outcome) begin
            for (int i = 0; i < SLOTS; i++) begin
                irq_en_reg[i] <= writedata[i*PAIR_W+EN_OFS];
            end
        end
    end

    // =========================================================
    // Program/erase lock, released by the flash reset command
    assign lock_set = (flag_sw_clear[SLOT_PROG_DONE] && flag_q[SLOT_PROG_DONE]
                       && !flag_set[SLOT_PROG_DONE])
                    || (flag_sw_clear[SLOT_ERASE_DONE] && flag_q[SLOT_ERASE_DONE]
                       && !flag_set[SLOT_ERASE_DONE])
                    || flag_set[SLOT_PROG_FAIL]
                    || flag_set[SLOT_ERASE_FAIL];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prog_erase_blocked <= 1'b0;
        end else if (lock_set) begin
            prog_erase_blocked <= 1'b1;
        end else if (reset_cmd) begin
            prog_erase_blocked <= 1'b0;
        end
    end

    // =========================================================
    // Event status (write one to clear) and mask
    always_comb begin
        evt_set = '0;
        evt_set[SLOTS-1:0] = flag_set;
        evt_set[EVT_LOCK] = lock_set && !prog_erase_blocked;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            evt_reg <= EVT_RESET;
        end else if (wr_evt_status) begin
            evt_reg <= (evt_reg & ~writedata[EVT_W-1:0]) | evt_set;
        end else begin
            evt_reg <= evt_reg | evt_set;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            evt_mask_reg <= EVT_RESET;
        end else if (wr_evt_mask) begin
            evt_mask_reg <= writedata[EVT_W-1:0];
        end
    end

    // Products of flags and enables, plus events whose mask bit is set
    assign irq = (|(flag_q & irq_en_reg))
               || (|(evt_reg & evt_mask_reg));

    // =========================================================
    // Read path
    always_comb begin
        rd_byte = OUTCOME_RESET;
        for (int i = 0; i < SLOTS; i++) begin
            rd_byte[i*PAIR_W+EN_OFS] = irq_en_reg[i];
            if (rmw_access) begin
                rd_byte[i*PAIR_W+FLAG_OFS] = 1'b1;
            end else begin
                rd_byte[i*PAIR_W+FLAG_OFS] = flag_q[i] && !flag_running[i];
            end
        end
    end

    always_comb begin
        rd_value = '0;
        if (hi_zero) begin
            case (addr_lo)
                OFS_OUTCOME: begin
                    rd_value[7:0] = rd_byte;
                end
                OFS_EVT_STATUS: begin
                    rd_value[EVT_W-1:0] = evt_reg;
                end
                OFS_EVT_MASK: begin
                    rd_value[EVT_W-1:0] = evt_mask_reg;
                end
                OFS_STATE: begin
                    rd_value[ST_BLOCKED] = prog_erase_blocked;
                    rd_value[ST_PROG_RUN] = state_reg == OP_PROG;
                    rd_value[ST_ERASE_RUN] = state_reg == OP_ERASE;
                    rd_value[ST_STUCK] = flash_stuck_indication;
                end
                default: begin
                    rd_value = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            readdata <= '0;
        end else if (read && !ack_reg) begin
            readdata <= rd_value;
        end
    end

    // =========================================================
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_prog_done_set: assert property (
        end_prog && !flash_stuck_indication |=> flag_q[SLOT_PROG_DONE])
        else $error("program-done flag not set at program end");

    a_prog_done_irq: assert property (
        flag_q[SLOT_PROG_DONE] && irq_en_reg[SLOT_PROG_DONE] |-> irq)
        else $error("program-done interrupt missing");

    a_stuck_clears_done: assert property (
        flash_stuck_indication |=> !flag_q[SLOT_PROG_DONE] && !flag_q[SLOT_ERASE_DONE])
        else $error("done flag survived stuck indication");

    a_sw_clear_zero: assert property (
        wr_outcome && !writedata[SLOT_ERASE_FAIL*PAIR_W+FLAG_OFS]
        && !flag_set[SLOT_ERASE_FAIL] |=> !flag_q[SLOT_ERASE_FAIL])
        else $error("write zero did not clear erase-fail flag");

    a_sw_write_one: assert property (
        wr_outcome && writedata[SLOT_PROG_FAIL*PAIR_W+FLAG_OFS]
        && flag_q[SLOT_PROG_FAIL] && !start_prog |=> flag_q[SLOT_PROG_FAIL])
        else $error("write one disturbed program-fail flag");

    a_rmw_ones: assert property (
        read && !ack_reg && rmw_access && hi_zero && addr_lo == OFS_OUTCOME
        |=> readdata[6] && readdata[4] && readdata[2] && readdata[0])
        else $error("read-modify-write read did not return ones");

    a_running_zero: assert property (
        read && !ack_reg && !rmw_access && hi_zero && addr_lo == OFS_OUTCOME
        && state_reg == OP_ERASE |=> !readdata[2] && !readdata[0])
        else $error("erase flags visible while erase runs");

    a_fail_blocks: assert property (
        flag_set[SLOT_PROG_FAIL] || flag_set[SLOT_ERASE_FAIL]
        |=> prog_erase_blocked)
        else $error("failure did not block program/erase");

    a_blocked_refuse: assert property (
        prog_erase_blocked && state_reg == OP_IDLE && op_start
        |=> state_reg == OP_IDLE)
        else $error("operation started while blocked");

    a_erase_done_set: assert property (
        end_erase && !flash_stuck_indication |=> ##0 flag_q[SLOT_ERASE_DONE])
        else $error("erase-done flag not set at erase end");

    a_prog_fail_irq: assert property (
        flag_q[SLOT_PROG_FAIL] && irq_en_reg[SLOT_PROG_FAIL] |-> irq)
        else $error("program-fail interrupt missing");

    a_erase_done_irq: assert property (
        flag_q[SLOT_ERASE_DONE] && irq_en_reg[SLOT_ERASE_DONE] |-> irq)
        else $error("erase-done interrupt missing");

    a_erase_fail_irq: assert property (
        flag_q[SLOT_ERASE_FAIL] && irq_en_reg[SLOT_ERASE_FAIL] |-> irq)
        else $error("erase-fail interrupt missing");

    a_erase_fail_set: assert property (
        end_erase && flash_stuck_indication |=> flag_q[SLOT_ERASE_FAIL])
        else $error("erase-fail flag not set at failed erase end");

    a_done_clear_blocks: assert property (
        wr_outcome && !writedata[SLOT_PROG_DONE*PAIR_W+FLAG_OFS]
        && flag_q[SLOT_PROG_DONE] && !end_prog |=> prog_erase_blocked)
        else $error("clearing program-done flag did not block");

endmodule

// ===== tb.sv
// Purpose: Self-checking bench for the flash outcome register block.
// Assumes: One wait state per bus access, strobes one cycle long.
// Notes: Each scenario starts from a fresh reset.
`timescale 1ns/1ns
module tb;
    import flash_outcome_pkg::*;
    // ==============================================
    // Signals and instance
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [4:0] address = 5'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic rmw_access = 1'b0;
    logic op_start = 1'b0;
    logic op_is_erase = 1'b0;
    logic op_end = 1'b0;
    logic flash_stuck_indication = 1'b0;
    logic reset_cmd = 1'b0;
    logic prog_erase_blocked;
    logic irq;
    logic [31:0] rd;
    int num_errors = 0;
    int tests_run = 0;

    always #4 clock = ~clock;

    flash_outcome_regs #(.ADDR_W(5)) i_dut (
        .clock(clock),
        .rst(rst),
        .address(address),
        .read(read),
        .write(write),
        .byteenable(byteenable),
        .writedata(writedata),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .rmw_access(rmw_access),
        .op_start(op_start),
        .op_is_erase(op_is_erase),
        .op_end(op_end),
        .flash_stuck_indication(flash_stuck_indication),
        .reset_cmd(reset_cmd),
        .prog_erase_blocked(prog_erase_blocked),
        .irq(irq)
    );

    // ==============================================
    // Shared tasks
    task results;
        $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, input logic rmw);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= wd;
        rmw_access <= rmw;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            num_errors++;
            results();
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        rmw_access <= 1'b0;
    endtask

    task wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 1'b0);
    endtask

    task rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 1'b0);
        chk(name, rd, exp);
    endtask

    task pins(input logic exp_irq, input logic exp_blk);
        @(posedge clock);
        @(negedge clock);
        chk("irq", {31'h0, irq}, {31'h0, exp_irq});
        chk("blocked", {31'h0, prog_erase_blocked}, {31'h0, exp_blk});
    endtask

    task do_reset;
        @(posedge clock);
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
    endtask

    task op_begin(input logic e);
        @(posedge clock);
        op_start <= 1'b1;
        op_is_erase <= e;
        @(posedge clock);
        op_start <= 1'b0;
    endtask

    task op_finish(input logic s);
        @(posedge clock);
        op_end <= 1'b1;
        flash_stuck_indication <= s;
        @(posedge clock);
        op_end <= 1'b0;
        flash_stuck_indication <= 1'b0;
    endtask

    task flash_reset;
        @(posedge clock);
        reset_cmd <= 1'b1;
        @(posedge clock);
        reset_cmd <= 1'b0;
    endtask

    // ==============================================
    // Scenarios
    task t_reset;
        do_reset();
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'h0);
        rd_chk("state", {1'b0, OFS_STATE}, 32'h0);
        wr(5'h10, 32'hff);
        rd_chk("unmapped", 5'h10, 32'h0);
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'h0);
        pins(1'b0, 1'b0);
    endtask

    task t_prog_ok;
        do_reset();
        op_begin(1'b0);
        rd_chk("state", {1'b0, OFS_STATE}, 32'h2);
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'h0);
        op_finish(1'b0);
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'h40);
        pins(1'b0, 1'b0);
        wr({1'b0, OFS_OUTCOME}, 32'hd5);
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'hc0);
        pins(1'b1, 1'b0);
        wr({1'b0, OFS_OUTCOME}, 32'h80);
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'h80);
        pins(1'b0, 1'b1);
        op_begin(1'b0);
        rd_chk("state", {1'b0, OFS_STATE}, 32'h1);
        flash_reset();
        pins(1'b0, 1'b0);
    endtask

    task t_prog_fail;
        do_reset();
        wr({1'b0, OFS_OUTCOME}, 32'h20);
        op_begin(1'b0);
        op_finish(1'b1);
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'h30);
        pins(1'b1, 1'b1);
        wr({1'b0, OFS_OUTCOME}, 32'h20);
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'h20);
        pins(1'b0, 1'b1);
        flash_reset();
        pins(1'b0, 1'b0);
    endtask

    task t_erase_ok;
        do_reset();
        op_begin(1'b1);
        rd_chk("state", {1'b0, OFS_STATE}, 32'h4);
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'h0);
        op_finish(1'b0);
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'h04);
        pins(1'b0, 1'b0);
        wr({1'b0, OFS_OUTCOME}, 32'h5d);
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'h0c);
        pins(1'b1, 1'b0);
        wr({1'b0, OFS_OUTCOME}, 32'h08);
        pins(1'b0, 1'b1);
        op_begin(1'b1);
        rd_chk("state", {1'b0, OFS_STATE}, 32'h1);
        flash_reset();
        pins(1'b0, 1'b0);
    endtask

    task t_erase_fail;
        do_reset();
        op_begin(1'b0);
        op_finish(1'b0);
        wr({1'b0, OFS_OUTCOME}, 32'h56);
        op_begin(1'b1);
        op_finish(1'b1);
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'h03);
        pins(1'b1, 1'b1);
        wr({1'b0, OFS_OUTCOME}, 32'h00);
        pins(1'b0, 1'b1);
        flash_reset();
        pins(1'b0, 1'b0);
    endtask

    task t_rmw;
        do_reset();
        wr({1'b0, OFS_OUTCOME}, 32'h28);
        bus(1'b0, {1'b0, OFS_OUTCOME}, 32'h0, 1'b1);
        chk("rmw read", rd, 32'h7d);
        rd_chk("outcome", {1'b0, OFS_OUTCOME}, 32'h28);
    endtask

    task t_events;
        do_reset();
        wr({1'b0, OFS_EVT_MASK}, 32'h08);
        op_begin(1'b0);
        op_finish(1'b0);
        pins(1'b1, 1'b0);
        rd_chk("event status", {1'b0, OFS_EVT_STATUS}, 32'h08);
        wr({1'b0, OFS_EVT_MASK}, 32'h00);
        pins(1'b0, 1'b0);
        wr({1'b0, OFS_EVT_MASK}, 32'h08);
        pins(1'b1, 1'b0);
        wr({1'b0, OFS_EVT_STATUS}, 32'h08);
        pins(1'b0, 1'b0);
        rd_chk("event status", {1'b0, OFS_EVT_STATUS}, 32'h0);
        wr({1'b0, OFS_OUTCOME}, 32'hd5);
        pins(1'b1, 1'b0);
    endtask

    // ==============================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_prog_ok();
        t_prog_fail();
        t_erase_ok();
        t_erase_fail();
        t_rmw();
        t_events();
        results();
    end
endmodule
